// ==== rtl/tc16_ctrl_regs.sv ====
// Control registers of the 16-bit timer behind an AHB-Lite slave
`default_nettype none
// Overview of operation
// - Prescale code picks divide 1..1024
// - Enable bit starts timer, resets off
// - Pin-drive enables route waveform to pins
// - Auto lock holds until enabled buffers valid
// - Next update copies and relocks
// - Without auto lock hardware never alters lock
// - Normal and frequency update at top when counting up
// - PWM modes update and overflow per code
// - Normal mode drives no waveform pins while enabled
// - Disabled timer outputs software levels
// - Pad needs pin enable, logic unit not
// - Split select makes two byte timers
// - Clear view clears written one bits
// - Set view sets written one bits
// - Command field reads zero
// - Commands update, restart, reset if disabled
// - Unlocked update copies buffers
// - Locked update blocked, forced copy allowed
// - Direction bit, hardware or software
// - Compare buffer write sets valid bit
// - Period buffer write sets valid bit
module tc16_ctrl_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic count_at_top,
  input wire logic count_at_bottom,
  input wire logic dir_hw_load,
  input wire logic dir_hw_value,
  input wire logic [tc16_pkg::CH_N-1:0] compare_buffer_write,
  input wire logic period_buffer_write,
  input wire logic [tc16_pkg::CH_N-1:0] waveform_output_n,
  output logic count_tick,
  output logic timer_enabled,
  output tc16_pkg::tc16_wave_e waveform_kind_select,
  output logic top_from_compare_zero,
  output logic dual_byte_select,
  output logic count_down,
  output logic update_lock,
  output logic [tc16_pkg::CH_N-1:0] compare_buffer_valid,
  output logic period_buffer_valid,
  output logic buffers_copy,
  output logic update_event,
  output logic overflow_event,
  output logic force_restart,
  output logic force_hard_reset,
  output logic [tc16_pkg::CH_N-1:0] wave_pad_out,
  output logic [tc16_pkg::CH_N-1:0] wave_pad_oe,
  output logic [tc16_pkg::CH_N-1:0] wave_logic_out
);
  import tc16_pkg::*;
  // ****************
  // Register state
  // ****************
  logic enable;
  logic [2:0] prescale_select;
  logic [CH_N-1:0] compare_pin_drive_en;
  logic auto_update_lock;
  logic [CH_N-1:0] compare_output_level;
  logic dir;
  logic lock;
  logic [CH_N-1:0] cbv;
  logic pbv;
  tc16_bus_e state;
  logic wr_phase;
  logic [IDX_W-1:0] dp_idx;
  logic [IDX_W-1:0] rd_idx;
  logic tick_w;
  tc16_presc_if pif ();
  tc16_prescaler #(.DIV_W(10)) u_presc (
    .hclk(hclk),
    .hresetn(hresetn),
    .pif(pif)
  );
  assign pif.sel = prescale_select;
  assign pif.run = enable;
  assign pif.restart = force_restart | wr_a;
  assign tick_w = pif.tick;
  // ****************
  // Bus decode
  // ****************
  wire logic acc = hsel & htrans[1] & hready;
  wire logic [IDX_W-1:0] a_idx = haddr[IDX_W+1:2];
  wire logic [7:0] wd = hwdata[7:0];
  wire logic wr_a = wr_phase & (dp_idx == IDX_CLOCK_AND_ENABLE);
  wire logic wr_b = wr_phase & (dp_idx == IDX_WAVEFORM_OUTPUT_CONFIG);
  wire logic wr_c = wr_phase & (dp_idx == IDX_OUTPUT_LEVEL_OVERRIDE);
  wire logic wr_d = wr_phase & (dp_idx == IDX_SPLIT_SELECT);
  wire logic wr_clr = wr_phase & (dp_idx == IDX_CONTROL_E_BIT_CLEAR);
  wire logic wr_set = wr_phase & (dp_idx == IDX_CONTROL_E_BIT_SET);
  wire logic wr_e = wr_clr | wr_set;
  wire tc16_cmd_e cmd = tc16_cmd_e'(wd[CMD_LSB+1:CMD_LSB]);
  wire logic [7:0] rd_e = {4'h0, 2'h0, lock, dir};
  wire logic [7:0] rd_byte =
    (rd_idx == IDX_CLOCK_AND_ENABLE) ? {4'h0, prescale_select, enable} :
    (rd_idx == IDX_WAVEFORM_OUTPUT_CONFIG) ?
      {1'b0, compare_pin_drive_en, auto_update_lock, waveform_kind_select} :
    (rd_idx == IDX_OUTPUT_LEVEL_OVERRIDE) ? {5'h00, compare_output_level} :
    (rd_idx == IDX_SPLIT_SELECT) ? {7'h00, dual_byte_select} :
    (rd_idx == IDX_CONTROL_E_BIT_CLEAR || rd_idx == IDX_CONTROL_E_BIT_SET) ? rd_e :
    8'h00;
  wire logic mapped = (haddr[31:IDX_W+2] == '0) & (a_idx <= IDX_CONTROL_E_BIT_SET);
  // ****************
  // Mode decode
  // ****************
  wire logic up_top = count_at_top & ~dir;
  wire logic upd_pt =
    (waveform_kind_select == wave_normal || waveform_kind_select == frequency_mode) ?
      up_top :
    (waveform_kind_select == single_ramp_pwm || waveform_kind_select[2]
      && waveform_kind_select != wave_reserved_b) ? count_at_bottom : 1'b0;
  wire logic ovf_pt =
    (waveform_kind_select == wave_normal || waveform_kind_select == frequency_mode) ?
      up_top :
    (waveform_kind_select == single_ramp_pwm) ? count_at_bottom :
    (waveform_kind_select == dual_ramp_top_irq) ? count_at_top :
    (waveform_kind_select == dual_ramp_both_irq) ? (count_at_top | count_at_bottom) :
    (waveform_kind_select == dual_ramp_bottom_irq) ? count_at_bottom : 1'b0;
  wire logic upd_evt = enable & upd_pt;
  // ****************
  // Update lock
  // ****************
  wire logic forced_upd = wr_e & (cmd == cmd_update);
  wire logic copy = (upd_evt & ~lock) | forced_upd;
  wire logic all_valid = &(cbv | ~compare_pin_drive_en);
  wire logic auto_rise = wr_b & wd[AUTO_LOCK_BIT] & ~auto_update_lock;
  wire logic sw_lock = (wr_set & wd[LOCK_BIT]) ? 1'b1 :
    (wr_clr & wd[LOCK_BIT]) ? 1'b0 : lock;
  wire logic next_lock = auto_rise ? 1'b1 :
    !auto_update_lock ? sw_lock :
    copy ? 1'b1 :
    (lock & all_valid) ? 1'b0 : sw_lock;
  wire logic next_dir = dir_hw_load ? dir_hw_value :
    (wr_set & wd[DIR_BIT]) ? 1'b1 : (wr_clr & wd[DIR_BIT]) ? 1'b0 : dir;
  wire logic [CH_N-1:0] next_cbv = (cbv & ~{CH_N{copy}}) | compare_buffer_write;
  wire logic next_pbv = (pbv & ~copy) | period_buffer_write;
  // ****************
  // Waveform routing
  // ****************
  wire logic [CH_N-1:0] level_sel = enable ? waveform_output_n : compare_output_level;
  wire logic wave_mode = (waveform_kind_select != wave_normal) | ~enable;
  assign count_down = dir;
  assign update_lock = lock;
  assign compare_buffer_valid = cbv;
  assign period_buffer_valid = pbv;
  assign timer_enabled = enable;
  assign count_tick = tick_w;
  // ****************
  // Bus slave
  // ****************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= bus_idle;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      wr_phase <= 1'b0;
      dp_idx <= '0;
      rd_idx <= '0;
    end else begin
      case (state)
        bus_idle: begin
          wr_phase <= acc & hwrite & mapped;
          dp_idx <= a_idx;
          rd_idx <= mapped ? a_idx : 3'h7;
          if (acc && !hwrite) begin
            state <= bus_read_wait;
            hreadyout <= 1'b0;
          end
        end
        bus_read_wait: begin
          wr_phase <= 1'b0;
          hrdata <= {24'h00_0000, rd_byte};
          hreadyout <= 1'b1;
          state <= bus_idle;
        end
        default: begin
          state <= bus_idle;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end
  // ****************
  // Control fields
  // ****************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable <= RST_CLOCK_AND_ENABLE[ENABLE_BIT];
      prescale_select <= RST_CLOCK_AND_ENABLE[PRESCALE_LSB+2:PRESCALE_LSB];
      waveform_kind_select <= tc16_wave_e'(RST_WAVEFORM_OUTPUT_CONFIG[WAVE_LSB+2:WAVE_LSB]);
      auto_update_lock <= RST_WAVEFORM_OUTPUT_CONFIG[AUTO_LOCK_BIT];
      compare_pin_drive_en <= RST_WAVEFORM_OUTPUT_CONFIG[PIN_EN_LSB+CH_N-1:PIN_EN_LSB];
      compare_output_level <= RST_OUTPUT_LEVEL_OVERRIDE[LEVEL_LSB+CH_N-1:LEVEL_LSB];
      dual_byte_select <= RST_SPLIT_SELECT[DUAL_BIT];
      dir <= RST_CONTROL_E[DIR_BIT];
      lock <= RST_CONTROL_E[LOCK_BIT];
      cbv <= '0;
      pbv <= 1'b0;
    end else begin
      if (wr_a) begin
        enable <= wd[ENABLE_BIT];
        prescale_select <= wd[PRESCALE_LSB+2:PRESCALE_LSB];
      end
      if (wr_b) begin
        waveform_kind_select <= tc16_wave_e'(wd[WAVE_LSB+2:WAVE_LSB]);
        auto_update_lock <= wd[AUTO_LOCK_BIT];
        compare_pin_drive_en <= wd[PIN_EN_LSB+CH_N-1:PIN_EN_LSB];
      end
      if (wr_c) begin
        compare_output_level <= wd[LEVEL_LSB+CH_N-1:LEVEL_LSB];
      end
      if (wr_d) begin
        dual_byte_select <= wd[DUAL_BIT];
      end
      dir <= next_dir;
      lock <= next_lock;
      cbv <= next_cbv;
      pbv <= next_pbv;
    end
  end
  // ****************
  // Events and pins
  // ****************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buffers_copy <= 1'b0;
      update_event <= 1'b0;
      overflow_event <= 1'b0;
      force_restart <= 1'b0;
      force_hard_reset <= 1'b0;
      top_from_compare_zero <= 1'b0;
      wave_pad_out <= '0;
      wave_pad_oe <= '0;
      wave_logic_out <= '0;
    end else begin
      buffers_copy <= copy;
      update_event <= upd_evt;
      overflow_event <= enable & ovf_pt;
      force_restart <= wr_e & (cmd == cmd_restart);
      force_hard_reset <= wr_e & (cmd == cmd_hard_reset) & ~enable;
      top_from_compare_zero <= waveform_kind_select == frequency_mode;
      wave_pad_out <= level_sel;
      wave_pad_oe <= compare_pin_drive_en & {CH_N{wave_mode}};
      wave_logic_out <= level_sel;
    end
  end
  // ****************
  // Checks
  // ****************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_div_two_gap: assert property (
    (count_tick && prescale_select == 3'h1 && enable) |=> !count_tick)
    else $error("tick too close for divide by two");
  a_tick_needs_en: assert property (
    count_tick |-> $past(enable))
    else $error("tick while disabled");
  a_tick_stops: assert property (
    !enable |=> !count_tick)
    else $error("tick after disable");
  a_pin_route: assert property (
    (enable && wave_mode) |=> wave_pad_oe == $past(compare_pin_drive_en))
    else $error("pin enable not routed");
  a_pad_wave: assert property (
    enable |=> wave_pad_out == $past(waveform_output_n))
    else $error("waveform not on pad");
  a_auto_unlock: assert property (
    (auto_update_lock && lock && all_valid && !copy && !wr_e && !wr_b) |=> !lock)
    else $error("auto lock not released");
  a_auto_hold: assert property (
    (auto_update_lock && lock && !all_valid && !wr_e) |=> lock)
    else $error("auto lock released early");
  a_auto_relock: assert property (
    (auto_update_lock && !lock && upd_evt && !wr_b) |=> lock && buffers_copy)
    else $error("update did not relock");
  a_lock_static: assert property (
    (!auto_update_lock && !wr_e && !wr_b) |=> $stable(lock))
    else $error("lock changed by hardware");
  a_normal_top: assert property (
    (enable && waveform_kind_select == wave_normal && up_top)
    |=> update_event && overflow_event)
    else $error("normal top missed");
  a_freq_top: assert property (
    waveform_kind_select == frequency_mode |=> top_from_compare_zero)
    else $error("frequency top not from compare");
  a_reserved_quiet: assert property (
    (waveform_kind_select == wave_reserved_a || waveform_kind_select == wave_reserved_b)
    |=> !update_event && !overflow_event)
    else $error("reserved mode raised event");
  a_single_bottom: assert property (
    (enable && waveform_kind_select == single_ramp_pwm && count_at_bottom)
    |=> update_event && overflow_event)
    else $error("single slope bottom missed");
  a_dual_top: assert property (
    (enable && waveform_kind_select == dual_ramp_top_irq && count_at_top && !count_at_bottom)
    |=> overflow_event && !update_event)
    else $error("dual slope top wrong");
  a_normal_no_pin: assert property (
    (enable && waveform_kind_select == wave_normal) |=> wave_pad_oe == '0)
    else $error("normal mode drove pin");
  a_level_override: assert property (
    !enable |=> wave_logic_out == $past(compare_output_level))
    else $error("override level not passed");
  a_disabled_pad: assert property (
    !enable |=> wave_pad_out == $past(compare_output_level)
      && wave_pad_oe == $past(compare_pin_drive_en))
    else $error("override not gated by pin enable");
  a_split_write: assert property (
    wr_d |=> dual_byte_select == $past(wd[DUAL_BIT]))
    else $error("split select not written");
  a_clear_view: assert property (
    (wr_clr && wd[DIR_BIT] && !dir_hw_load) |=> !count_down)
    else $error("clear view did not clear");
  a_set_view: assert property (
    (wr_set && wd[DIR_BIT] && !dir_hw_load) |=> count_down)
    else $error("set view did not set");
  a_cmd_read_zero: assert property (
    (state == bus_read_wait && rd_idx[2]) |=> hrdata[3:2] == 2'h0)
    else $error("command field read nonzero");
  a_reset_ignored: assert property (
    (wr_e && cmd == cmd_hard_reset && enable) |=> !force_hard_reset)
    else $error("hard reset while enabled");
  a_unlocked_copy: assert property (
    (!lock && upd_evt) |=> buffers_copy)
    else $error("unlocked update not copied");
  a_locked_hold: assert property (
    (lock && upd_evt && !forced_upd) |=> !buffers_copy)
    else $error("locked update copied");
  a_dir_hw: assert property (
    dir_hw_load |=> count_down == $past(dir_hw_value))
    else $error("hardware direction not loaded");
  a_valid_set: assert property (
    compare_buffer_write[0] |=> compare_buffer_valid[0])
    else $error("buffer valid not set");
  a_valid_clear: assert property (
    (copy && !compare_buffer_write[0] && !period_buffer_write)
    |=> !compare_buffer_valid[0] && !period_buffer_valid)
    else $error("valid bit kept after copy");
  a_zero_keeps: assert property (
    (wr_e && wd[LOCK_BIT:DIR_BIT] == 2'h0 && !dir_hw_load && !auto_update_lock)
    |=> $stable(count_down) && $stable(update_lock))
    else $error("zero bit changed state");
endmodule : tc16_ctrl_regs
`default_nettype wire

// ==== rtl/tc16_pkg.sv ====
// Shared constants and types of the timer control register block
`default_nettype none
package tc16_pkg;
  // ****************
  // Register indices
  // ****************
  localparam int IDX_W = 3;
  localparam logic [IDX_W-1:0] IDX_CLOCK_AND_ENABLE = 3'h0;
  localparam logic [IDX_W-1:0] IDX_WAVEFORM_OUTPUT_CONFIG = 3'h1;
  localparam logic [IDX_W-1:0] IDX_OUTPUT_LEVEL_OVERRIDE = 3'h2;
  localparam logic [IDX_W-1:0] IDX_SPLIT_SELECT = 3'h3;
  localparam logic [IDX_W-1:0] IDX_CONTROL_E_BIT_CLEAR = 3'h4;
  localparam logic [IDX_W-1:0] IDX_CONTROL_E_BIT_SET = 3'h5;
  // ****************
  // Field positions
  // ****************
  localparam int CH_N = 3;
  localparam int ENABLE_BIT = 0;
  localparam int PRESCALE_LSB = 1;
  localparam int WAVE_LSB = 0;
  localparam int AUTO_LOCK_BIT = 3;
  localparam int PIN_EN_LSB = 4;
  localparam int LEVEL_LSB = 0;
  localparam int DUAL_BIT = 0;
  localparam int DIR_BIT = 0;
  localparam int LOCK_BIT = 1;
  localparam int CMD_LSB = 2;
  // ****************
  // Reset values
  // ****************
  localparam logic [7:0] RST_CLOCK_AND_ENABLE = 8'h00;
  localparam logic [7:0] RST_WAVEFORM_OUTPUT_CONFIG = 8'h00;
  localparam logic [7:0] RST_OUTPUT_LEVEL_OVERRIDE = 8'h00;
  localparam logic [7:0] RST_SPLIT_SELECT = 8'h00;
  localparam logic [7:0] RST_CONTROL_E = 8'h00;
  // ****************
  // Types
  // ****************
  typedef enum logic [2:0] {
    wave_normal = 3'h0,
    frequency_mode = 3'h1,
    wave_reserved_a = 3'h2,
    single_ramp_pwm = 3'h3,
    wave_reserved_b = 3'h4,
    dual_ramp_top_irq = 3'h5,
    dual_ramp_both_irq = 3'h6,
    dual_ramp_bottom_irq = 3'h7
  } tc16_wave_e;
  typedef enum logic [1:0] {
    cmd_none = 2'h0,
    cmd_update = 2'h1,
    cmd_restart = 2'h2,
    cmd_hard_reset = 2'h3
  } tc16_cmd_e;
  typedef enum logic {
    bus_idle = 1'b0,
    bus_read_wait = 1'b1
  } tc16_bus_e;
  // Division exponent per prescale code
  function automatic logic [3:0] tc16_presc_shift(input logic [2:0] sel);
    case (sel)
      3'h0: tc16_presc_shift = 4'h0;
      3'h1: tc16_presc_shift = 4'h1;
      3'h2: tc16_presc_shift = 4'h2;
      3'h3: tc16_presc_shift = 4'h3;
      3'h4: tc16_presc_shift = 4'h4;
      3'h5: tc16_presc_shift = 4'h6;
      3'h6: tc16_presc_shift = 4'h8;
      default: tc16_presc_shift = 4'hA;
    endcase
  endfunction : tc16_presc_shift
endpackage : tc16_pkg
`default_nettype wire

// ==== rtl/tc16_presc_if.sv ====
// Link between the control logic and the prescaler
`default_nettype none
interface tc16_presc_if;
  logic [2:0] sel;
  logic run;
  logic restart;
  logic tick;
  modport ctrl (output sel, output run, output restart, input tick);
  modport presc (input sel, input run, input restart, output tick);
endinterface : tc16_presc_if
`default_nettype wire

// ==== rtl/tc16_prescaler.sv ====
// Count clock prescaler producing a one-cycle tick
`default_nettype none
module tc16_prescaler #(
  parameter int DIV_W = 10
) (
  input wire logic hclk,
  input wire logic hresetn,
  tc16_presc_if.presc pif
);
  import tc16_pkg::*;
  logic [DIV_W-1:0] cnt;
  logic tick_q;
  wire logic [3:0] shift = tc16_presc_shift(pif.sel);
  wire logic [DIV_W:0] one_hot = (DIV_W+1)'(1) << shift;
  wire logic [DIV_W-1:0] mask = DIV_W'(one_hot - (DIV_W+1)'(1));
  wire logic hit = (cnt & mask) == mask;
  assign pif.tick = tick_q;
  // ****************
  // Divider
  // ****************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= '0;
      tick_q <= 1'b0;
    end else if (!pif.run || pif.restart) begin
      cnt <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt <= cnt + DIV_W'(1);
      tick_q <= hit;
    end
  end
endmodule : tc16_prescaler
`default_nettype wire

// ==== verification/tc16_ctrl_regs_tb_top.sv ====
// Self-checking testbench of the timer control register block
`default_nettype none
module tc16_ctrl_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tc16_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata;
  logic count_at_top = 1'b0, count_at_bottom = 1'b0;
  logic dir_hw_load = 1'b0, dir_hw_value = 1'b0, period_buffer_write = 1'b0;
  logic [2:0] compare_buffer_write = 3'h0, waveform_output_n = 3'h0;
  logic count_tick, timer_enabled, top_from_compare_zero, dual_byte_select, count_down;
  logic update_lock, period_buffer_valid, buffers_copy, update_event, overflow_event;
  logic force_restart, force_hard_reset;
  logic [2:0] compare_buffer_valid, wave_pad_out, wave_pad_oe, wave_logic_out;
  tc16_wave_e waveform_kind_select;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [31:0] exp_q[$];
  logic rd_dp = 1'b0;
  logic [7:0] d;
  int n;
  tc16_ctrl_regs i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .count_at_top, .count_at_bottom,
    .dir_hw_load, .dir_hw_value, .compare_buffer_write, .period_buffer_write,
    .waveform_output_n, .count_tick, .timer_enabled, .waveform_kind_select,
    .top_from_compare_zero, .dual_byte_select, .count_down, .update_lock,
    .compare_buffer_valid, .period_buffer_valid, .buffers_copy, .update_event,
    .overflow_event, .force_restart, .force_hard_reset, .wave_pad_out, .wave_pad_oe,
    .wave_logic_out);
  always #20 hclk = ~hclk;
  // ****************
  // Checking
  // ****************
  task summarize;
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task chk_rd(input logic [31:0] got);
    total_checks++;
    if (exp_q.size() == 0 || got !== exp_q[0]) begin
      n_mismatch++;
      $display("[FAIL] %0t read data %h", $time, got);
    end
    if (exp_q.size() != 0) void'(exp_q.pop_front());
  endtask : chk_rd
  // Read data phase ends when ready returns high
  always @(posedge hclk) begin
    if (rd_dp && hreadyout === 1'b1) chk_rd(hrdata);
    rd_dp <= (hsel & htrans[1] & hreadyout & ~hwrite) | (rd_dp & ~hreadyout);
  end
  // ****************
  // Drivers
  // ****************
  task wait_rdy;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      summarize();
    end
  endtask : wait_rdy
  // For reads, d is the expected register byte
  task bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wr ? {24'h0, d} : 32'hA5A5_5A5A;
    if (!wr) exp_q.push_back({24'h0, d});
    wait_rdy();
  endtask : bus
  task ev(input logic t, input logic b, input logic [2:0] cb, input logic pb);
    count_at_top <= t;
    count_at_bottom <= b;
    compare_buffer_write <= cb;
    period_buffer_write <= pb;
    @(posedge hclk);
    count_at_top <= 1'b0;
    count_at_bottom <= 1'b0;
    compare_buffer_write <= 3'h0;
    period_buffer_write <= 1'b0;
    @(posedge hclk);
  endtask : ev
  task wait_tick(input int lim, output int n);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (count_tick !== 1'b1 && n < lim);
    if (count_tick !== 1'b1) begin
      n_mismatch++;
      summarize();
    end
  endtask : wait_tick
  // ****************
  // Main sequence
  // ****************
  initial begin
    int sh[8];
    logic [7:0] msk[4];
    sh = '{0, 1, 2, 3, 4, 6, 8, 10};
    msk = '{8'h0F, 8'h7F, 8'h07, 8'h01};
    void'($urandom(32'h02ad6d95));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({timer_enabled, waveform_kind_select, count_down, update_lock}, 0, "reset out");
    for (int i = 0; i < 6; i++) bus(1'b0, i[7:0], 8'h00);
    bus(1'b1, 8'h07, 8'hFF);
    bus(1'b0, 8'h07, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      bus(1'b1, i[7:0], d);
      bus(1'b0, i[7:0], d & msk[i]);
      @(posedge hclk);
      if (i == 0) chk(timer_enabled, d[0], "enable");
      if (i == 3) chk(dual_byte_select, d[0], "split");
      bus(1'b1, i[7:0], 8'h00);
    end
    bus(1'b1, 8'h04, 8'h03);
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, 8'h00, {4'h0, k[2:0], 1'b1});
      wait_tick(1100, n);
      wait_tick(1100, n);
      chk(n, 1 << sh[k], "tick period");
    end
    bus(1'b1, 8'h00, 8'h00);
    repeat (2) @(posedge hclk);
    n = 0;
    repeat (40) begin
      @(posedge hclk);
      if (count_tick !== 1'b0) n++;
    end
    chk(n, 0, "tick while off");
    bus(1'b1, 8'h00, 8'h01);
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, 8'h01, m[7:0]);
      ev(1'b1, 1'b0, 3'h0, 1'b0);
      chk({waveform_kind_select, top_from_compare_zero}, {m[2:0], m == 1}, "mode");
      chk({update_event, overflow_event, buffers_copy}, {m < 2, 1'(8'h63 >> m), m < 2},
          "top pt");
      ev(1'b0, 1'b1, 3'h0, 1'b0);
      chk({update_event, overflow_event}, {1'(8'hE8 >> m), 1'(8'hC8 >> m)}, "bot pt");
    end
    bus(1'b1, 8'h01, 8'h00);
    bus(1'b1, 8'h05, 8'h01);
    ev(1'b1, 1'b0, 3'h0, 1'b0);
    chk({count_down, update_event}, 2'b10, "down no top");
    bus(1'b1, 8'h04, 8'h00);
    chk(count_down, 1'b1, "zero keeps");
    dir_hw_load <= 1'b1;
    @(posedge hclk);
    dir_hw_load <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(count_down, 1'b0, "hw dir");
    bus(1'b1, 8'h05, 8'h01);
    bus(1'b1, 8'h04, 8'h01);
    @(posedge hclk);
    chk(count_down, 1'b0, "clear dir");
    bus(1'b1, 8'h05, 8'h02);
    bus(1'b0, 8'h04, 8'h02);
    ev(1'b1, 1'b0, 3'h0, 1'b0);
    chk({update_event, buffers_copy, update_lock}, 3'b101, "locked");
    bus(1'b1, 8'h05, 8'h06);
    @(posedge hclk);
    chk(buffers_copy, 1'b1, "forced update");
    @(posedge hclk);
    chk(buffers_copy, 1'b0, "once");
    bus(1'b0, 8'h05, 8'h02);
    bus(1'b1, 8'h04, 8'h02);
    ev(1'b1, 1'b0, 3'h0, 1'b0);
    chk({buffers_copy, update_lock}, 2'b10, "unlocked");
    bus(1'b1, 8'h05, 8'h08);
    @(posedge hclk);
    chk(force_restart, 1'b1, "restart");
    bus(1'b1, 8'h05, 8'h0C);
    @(posedge hclk);
    chk(force_hard_reset, 1'b0, "reset ignored");
    bus(1'b1, 8'h00, 8'h00);
    bus(1'b1, 8'h04, 8'h0C);
    @(posedge hclk);
    chk(force_hard_reset, 1'b1, "hard reset");
    bus(1'b1, 8'h05, 8'h00);
    @(posedge hclk);
    chk({buffers_copy, force_restart, force_hard_reset}, 0, "no cmd");
    bus(1'b1, 8'h00, 8'h01);
    bus(1'b1, 8'h01, 8'h3B);
    repeat (2) @(posedge hclk);
    chk(update_lock, 1'b1, "auto set");
    ev(1'b0, 1'b0, 3'h1, 1'b0);
    repeat (2) @(posedge hclk);
    chk({update_lock, compare_buffer_valid}, 4'h9, "one valid");
    ev(1'b0, 1'b0, 3'h2, 1'b1);
    repeat (2) @(posedge hclk);
    chk({update_lock, period_buffer_valid}, 2'b01, "all valid");
    ev(1'b0, 1'b1, 3'h0, 1'b0);
    chk(buffers_copy, 1'b1, "auto copy");
    repeat (2) @(posedge hclk);
    chk({update_lock, compare_buffer_valid, period_buffer_valid}, 5'h10,
        "relock");
    bus(1'b1, 8'h01, 8'h70);
    bus(1'b1, 8'h00, 8'h00);
    bus(1'b1, 8'h02, 8'h05);
    repeat (3) @(posedge hclk);
    chk({wave_pad_out, wave_pad_oe, wave_logic_out}, 9'h17D, "override");
    bus(1'b1, 8'h01, 8'h00);
    repeat (3) @(posedge hclk);
    chk({wave_pad_oe, wave_logic_out}, 6'h05, "no pin en");
    waveform_output_n <= 3'($urandom);
    bus(1'b1, 8'h01, 8'h53);
    bus(1'b1, 8'h00, 8'h01);
    repeat (3) @(posedge hclk);
    chk({wave_pad_out, wave_pad_oe, wave_logic_out},
        {waveform_output_n, 3'h5, waveform_output_n}, "pwm pins");
    bus(1'b1, 8'h01, 8'h50);
    repeat (3) @(posedge hclk);
    chk(wave_pad_oe, 3'h0, "normal no pins");
    chk(hresp, 1'b0, "okay");
    repeat (2) @(posedge hclk);
    summarize();
  end
endmodule : tc16_ctrl_regs_tb_top
`default_nettype wire
